//--- pin_sync3.v
// Purpose: Three-stage synchroniser with agreement qualify
// Assumes: Input is asynchronous to clk
// Notes: A change is accepted once stages two and three agree
`timescale 1ns/1ps

module pin_sync3 #(
    // Level held through reset; matches the pin's idle level
    parameter [0:0] INIT = 1'b0
) (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Pin side
    input wire pin_in,
    // Qualified level
    output reg level_r
);

reg s1_r;
reg s2_r;
reg s3_r;

// Stage one is read by stage two only, to keep metastability contained
always @(posedge clk or posedge rst) begin
    // Starting at the idle level avoids a false line change after reset
    if (rst) begin
        s1_r <= INIT;
        s2_r <= INIT;
        s3_r <= INIT;
        level_r <= INIT;
    end else begin
        s1_r <= pin_in;
        s2_r <= s1_r;
        s3_r <= s2_r;
        if (s2_r == s3_r) begin
            level_r <= s3_r;
        end
    end
end

endmodule

//--- test_usb_fs_line_state_detector.sv
// Purpose: Self-checking bench for the line state detector
// Assumes: Reset count shortened to 200 cycles
// Notes: Framing pulses are counted, so a missed one shows
`timescale 1ns/1ps
module test_usb_fs_line_state_detector;
    logic clk = 1'b0;
    logic rst = 1'b1;
    wire dp_in;
    wire dm_in;
    wire [1:0] line_state_r;
    wire idle_r, resume_r, sop_r, eop_r, in_packet_r, bus_reset_r;
    int n_checks = 0;
    int n_fail = 0;
    int n_sop = 0;
    int n_eop = 0;

    usb_host_line_model usb_host_line_model_inst (.clk(clk), .dp(dp_in), .dm(dm_in));
    usb_fs_line_state_detector #(.RESET_CYCLES(200)) usb_fs_line_state_detector_inst (
        .clk(clk), .rst(rst), .dp_in(dp_in), .dm_in(dm_in), .line_state_r(line_state_r),
        .idle_r(idle_r), .resume_r(resume_r), .sop_r(sop_r), .eop_r(eop_r),
        .in_packet_r(in_packet_r), .bus_reset_r(bus_reset_r));

    initial forever #4 clk = ~clk;

    // Pulses last one cycle, so count them as they pass
    always @(posedge clk) begin
        if (sop_r === 1'b1) n_sop++;
        if (eop_r === 1'b1) n_eop++;
    end

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %0h seen %0h", nm, exp, got);
        end
    endtask

    task automatic t_frame();
        usb_host_line_model_inst.line(2'h1, 80);
        usb_host_line_model_inst.line(2'h2, 10);
        chk("sop", n_sop, 1);
        chk("k state", line_state_r, 2'h2);
        chk("no resume", resume_r, 0);
        usb_host_line_model_inst.line(2'h1, 10);
        chk("in packet", in_packet_r, 1);
        usb_host_line_model_inst.line(2'h0, 20);
        usb_host_line_model_inst.line(2'h1, 20);
        chk("eop", n_eop, 1);
        chk("closed", in_packet_r, 0);
        $display("done frame");
    endtask

    // A short SE0 glitch must not end the packet
    task automatic t_short_se0();
        usb_host_line_model_inst.line(2'h1, 80);
        usb_host_line_model_inst.packet(4);
        chk("no eop", n_eop, 1);
        chk("still open", in_packet_r, 1);
        usb_host_line_model_inst.packet(11);
        chk("eop", n_eop, 2);
        $display("done short_se0");
    endtask

    // K after too little J is refused as a start; held K reads as resume
    task automatic t_no_idle();
        usb_host_line_model_inst.line(2'h1, 30);
        usb_host_line_model_inst.line(2'h2, 30);
        chk("no sop", n_sop, 2);
        chk("idle", idle_r, 0);
        chk("resume", resume_r, 1);
        $display("done no_idle");
    endtask

    task automatic t_reset();
        usb_host_line_model_inst.line(2'h0, 220);
        chk("se0", line_state_r, 2'h0);
        chk("bus reset", bus_reset_r, 1);
        usb_host_line_model_inst.line(2'h1, 20);
        chk("reset end", bus_reset_r, 0);
        chk("j", line_state_r, 2'h1);
        $display("done reset");
    endtask

    task automatic close_out();
        $display("checks %0d fails %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge clk);
        #1 rst = 1'b0;
        t_frame();
        t_short_se0();
        t_no_idle();
        t_reset();
        close_out();
    end

    // Whole run is near 650 cycles; allow ample margin
    initial begin
        #100000;
        n_fail++;
        close_out();
    end
endmodule

//--- usb_fs_line_state_detector.v
// Purpose: Receive line state, packet framing and bus reset detection
// Assumes: D+ and D- arrive as digital receiver levels from a pad
// Notes: Single clock; bit timing comes from cycle counting
//
// Overview of operation
// - Idle to K marks packet start
// - SE0 then J for one bit ends packet
// - EOP widths measured in approximate bit periods
// - Long continuous SE0 signals bus reset
// - Both lines low decode as SE0
// - Idle is J held without transitions
// - Bit timing derived from 12 Mb/s
`timescale 1ns/1ps
`include "usb_line_map.vh"

module usb_fs_line_state_detector #(
    parameter RESET_CYCLES = `RESET_CYCLES,
    parameter IDLE_BITS = 7
) (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Data line receiver levels
    input wire dp_in,
    input wire dm_in,
    // Decoded line state
    output reg [1:0] line_state_r,
    output reg idle_r,
    output reg resume_r,
    // Packet framing: start and end events one cycle each, plus in-packet level
    output reg sop_r,
    output reg eop_r,
    output reg in_packet_r,
    // Bus reset
    output reg bus_reset_r
);

localparam CW = 24;
localparam integer BIT_I = `BIT_CYCLES;
localparam integer BIT_MIN_I = `BIT_MIN_CYCLES;
localparam integer RST_I = RESET_CYCLES;
localparam integer IDLE_I = IDLE_BITS * `BIT_CYCLES;
// Counts are cut to the counter width on purpose; all fit in 24 bits
localparam [CW-1:0] BIT_N = BIT_I[CW-1:0];
localparam [CW-1:0] BIT_MIN = BIT_MIN_I[CW-1:0];
localparam [CW-1:0] RST_N = RST_I[CW-1:0];
localparam [CW-1:0] IDLE_N = IDLE_I[CW-1:0];

// Framing states
localparam ST_IDLE = 2'h0;
localparam ST_PKT = 2'h1;
localparam ST_SE0 = 2'h2;
localparam ST_EOPJ = 2'h3;

wire dp_s;
wire dm_s;
reg [1:0] ls_nxt;
reg [1:0] prev_ls_r;
reg [CW-1:0] run_r;
reg [1:0] st_r;
reg [1:0] st_nxt;
reg sop_nxt;
reg eop_nxt;

// ----------------------------------------
// Input synchronisers
// ----------------------------------------
// D+ idles high on a full-speed link
pin_sync3 #(
    .INIT(1'b1)
) u_sync_dp (
    .clk(clk),
    .rst(rst),
    .pin_in(dp_in),
    .level_r(dp_s)
);

pin_sync3 #(
    .INIT(1'b0)
) u_sync_dm (
    .clk(clk),
    .rst(rst),
    .pin_in(dm_in),
    .level_r(dm_s)
);

// ----------------------------------------
// Line state decode
// ----------------------------------------
// SE0 takes precedence over any differential reading
always @* begin
    if (!dp_s && !dm_s) begin
        ls_nxt = `LS_SE0;
    end else if (dp_s && !dm_s) begin
        ls_nxt = `LS_J;
    end else if (!dp_s && dm_s) begin
        ls_nxt = `LS_K;
    end else begin
        ls_nxt = `LS_SE1;
    end
end

// Run length of the current line state, saturating
always @(posedge clk or posedge rst) begin
    if (rst) begin
        line_state_r <= `LS_J;
        prev_ls_r <= `LS_J;
        run_r <= {CW{1'b0}};
    end else begin
        line_state_r <= ls_nxt;
        prev_ls_r <= line_state_r;
        if (ls_nxt != line_state_r) begin
            run_r <= {CW{1'b0}};
        end else if (run_r != {CW{1'b1}}) begin
            run_r <= run_r + 1'b1;
        end
    end
end

// ----------------------------------------
// Packet framing
// ----------------------------------------
// Bit periods are counted from the 12 Mb/s rate with a tolerant minimum,
// since the host's bit edges are only approximately aligned to our clock
always @* begin
    st_nxt = st_r;
    sop_nxt = 1'b0;
    eop_nxt = 1'b0;
    case (st_r)
        ST_IDLE: begin
            // Idle means J with no transitions for a few bit times
            if (line_state_r == `LS_K && prev_ls_r == `LS_J && idle_r) begin
                st_nxt = ST_PKT;
                sop_nxt = 1'b1;
            end
        end
        ST_PKT: begin
            if (line_state_r == `LS_SE0) begin
                st_nxt = ST_SE0;
            end
        end
        ST_SE0: begin
            if (line_state_r == `LS_J) begin
                // SE0 must have lasted at least an approximate bit time
                if (run_r >= BIT_MIN - 1'b1 || prev_ls_r != `LS_SE0) begin
                    st_nxt = ST_EOPJ;
                end
            end else if (line_state_r == `LS_K || line_state_r == `LS_SE1) begin
                st_nxt = ST_PKT;
            end
        end
        default: begin
            if (line_state_r != `LS_J) begin
                st_nxt = (line_state_r == `LS_SE0) ? ST_SE0 : ST_PKT;
            end else if (run_r >= BIT_MIN) begin
                st_nxt = ST_IDLE;
                eop_nxt = 1'b1;
            end
        end
    endcase
end

// Glitch filter on short SE0: the SE0 run is checked on leaving it
reg se0_ok_r;
always @(posedge clk or posedge rst) begin
    if (rst) begin
        se0_ok_r <= 1'b0;
    end else if (line_state_r == `LS_SE0) begin
        se0_ok_r <= (run_r + 1'b1 >= BIT_MIN);
    end
end

always @(posedge clk or posedge rst) begin
    if (rst) begin
        st_r <= ST_IDLE;
        sop_r <= 1'b0;
        eop_r <= 1'b0;
        in_packet_r <= 1'b0;
    end else begin
        if (st_r == ST_SE0 && st_nxt == ST_EOPJ && !se0_ok_r) begin
            st_r <= ST_PKT;
        end else begin
            st_r <= st_nxt;
        end
        sop_r <= sop_nxt;
        eop_r <= eop_nxt;
        in_packet_r <= (st_nxt != ST_IDLE);
    end
end

// ----------------------------------------
// Idle, resume and bus reset
// ----------------------------------------
// Reset holds while SE0 lasts; framing is left to the packet logic
always @(posedge clk or posedge rst) begin
    if (rst) begin
        idle_r <= 1'b0;
        resume_r <= 1'b0;
        bus_reset_r <= 1'b0;
    end else begin
        // Judged on the state before this edge, so idle still stands in the
        // cycle where K first shows and the start can be qualified by it
        idle_r <= (line_state_r == `LS_J) && (run_r >= IDLE_N - 1'b1);
        resume_r <= (st_r == ST_IDLE) && (line_state_r == `LS_K) &&
                    (run_r >= BIT_N);
        bus_reset_r <= (line_state_r == `LS_SE0) && (ls_nxt == `LS_SE0) &&
                       (run_r >= RST_N - 1'b1);
    end
end

endmodule

//--- usb_fs_line_state_sva.sv
// Purpose: Port checks for the line state detector
// Assumes: Pins change only once per several cycles
// Notes: Pin run counter lets checks allow the sync latency
`timescale 1ns/1ps
module usb_fs_line_state_sva #(
    parameter RESET_CYCLES = 200,
    parameter IDLE_BITS = 7
) (
    // Clock, reset and pins
    input wire clk,
    input wire rst,
    input wire dp_in,
    input wire dm_in,
    // Detector outputs
    input wire [1:0] line_state_r,
    input wire idle_r,
    input wire resume_r,
    input wire sop_r,
    input wire eop_r,
    input wire in_packet_r,
    input wire bus_reset_r
);
    logic [1:0] pins_r;
    logic [31:0] run_r;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Cycles the pin pair has held; saturates on long resets
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            pins_r <= 2'h1;
            run_r <= 32'h0;
        end else begin
            pins_r <= {dm_in, dp_in};
            if ({dm_in, dp_in} != pins_r)
                run_r <= 32'h0;
            else if (run_r != 32'hffffffff)
                run_r <= run_r + 32'h1;
        end
    end

    a_state_map: assert property (run_r >= 8 |-> line_state_r == pins_r)
        else $error("line state differs from pins");
    a_sop_from_k: assert property (sop_r |-> $past(line_state_r) == 2'h2)
        else $error("sop without K");
    a_sop_opens: assert property (sop_r |=> !sop_r && in_packet_r)
        else $error("sop not a pulse opening packet");
    a_eop_closes: assert property (eop_r |-> $past(in_packet_r) ##1 !eop_r && !in_packet_r)
        else $error("eop outside packet or sticky");
    a_eop_j_held: assert property (eop_r |-> run_r >= 7 && pins_r == 2'h1)
        else $error("eop before J bit");
    a_idle_time: assert property ($rose(idle_r) |-> run_r >= 10 * IDLE_BITS)
        else $error("idle too soon");
    a_idle_is_j: assert property (idle_r |-> $past(line_state_r) == 2'h1)
        else $error("idle not J");
    a_reset_min: assert property ($rose(bus_reset_r) |-> run_r >= RESET_CYCLES)
        else $error("bus reset too soon");
    a_reset_late: assert property (pins_r == 2'h0 && run_r == RESET_CYCLES + 16 |-> bus_reset_r)
        else $error("bus reset missed");
    a_resume_k: assert property (resume_r |-> !in_packet_r && $past(line_state_r) == 2'h2)
        else $error("resume without K");

    c_sop: cover property (sop_r);
    c_eop: cover property (eop_r);
    c_reset: cover property ($rose(bus_reset_r));
    c_resume: cover property ($rose(resume_r));
endmodule

bind usb_fs_line_state_detector usb_fs_line_state_sva #(.RESET_CYCLES(RESET_CYCLES),
    .IDLE_BITS(IDLE_BITS)) sva_inst (.clk(clk), .rst(rst), .dp_in(dp_in), .dm_in(dm_in),
    .line_state_r(line_state_r), .idle_r(idle_r), .resume_r(resume_r), .sop_r(sop_r),
    .eop_r(eop_r), .in_packet_r(in_packet_r), .bus_reset_r(bus_reset_r));

//--- usb_host_line_model.sv
// Purpose: Host port model driving D+ and D- line states
// Assumes: One state held for a whole number of clk cycles
// Notes: Lines change 1 ns after an edge, so sampling never races
`timescale 1ns/1ps
module usb_host_line_model (
    // Clock
    input wire clk,
    // Data lines
    output logic dp,
    output logic dm
);
    // Bus idles in J until the first command
    initial {dm, dp} = 2'h1;

    // Hold one line state, {dm, dp}, for n cycles
    task automatic line(input logic [1:0] st, input int n);
        {dm, dp} = st;
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Idle to K start, bits of 10-11 cycles, SE0 then J end
    task automatic packet(input int se0);
        line(2'h2, 10);
        line(2'h1, 10);
        line(2'h2, 11);
        line(2'h0, se0);
        line(2'h1, 20);
    endtask
endmodule

//--- usb_line_map.vh
// Purpose: Constants for the full-speed line state detector
// Assumes: 125 MHz system clock, 12 Mb/s full-speed link
// Notes: Times are in their own units; cycle counts derive from them
`ifndef USB_LINE_MAP_VH
`define USB_LINE_MAP_VH

// ----------------------------------------
// Clock and link rates
// ----------------------------------------
`define CLK_HZ 125000000
`define BIT_RATE_HZ 12000000
// Bit period in cycles, rounded down (10 cycles at 125 MHz)
`define BIT_CYCLES (`CLK_HZ / `BIT_RATE_HZ)
// Tolerated shortfall: a bit time of 0.75 nominal still qualifies
`define BIT_MIN_CYCLES ((`BIT_CYCLES * 3) / 4)

// ----------------------------------------
// Reset timing
// ----------------------------------------
`define RESET_TIME_US 10000
// Least time in whole cycles; the cycles per microsecond are rounded down
`define RESET_CYCLES ((`RESET_TIME_US * (`CLK_HZ / 1000000)))

// ----------------------------------------
// Line state codes
// ----------------------------------------
`define LS_SE0 2'h0
`define LS_J 2'h1
`define LS_K 2'h2
`define LS_SE1 2'h3

`endif
